/* File: fpbc_pkg.sv */
// package for flash protection and boot configuration block
// assumes a 50 MHz clock and an APB register bus
package fpbc_pkg;
    localparam int          LOCK_BITS      = 32;
    localparam int          PAGES_PER_LOCK = 64;
    localparam int          PAGES_PER_BANK = 1024;
    localparam int          PAGE_BYTES     = 256;
    localparam int          WBUF_WORDS     = 32;
    localparam int          GENERAL_NVM_BITS_BITS     = 3;
    // register byte offsets
    localparam logic [11:0] OFS_CMD        = 12'h000;
    localparam logic [11:0] OFS_STATUS     = 12'h004;
    localparam logic [11:0] OFS_LOCK       = 12'h008;
    localparam logic [11:0] OFS_NVM        = 12'h00C;
    localparam logic [11:0] OFS_CFG        = 12'h010;
    localparam logic [11:0] OFS_RESULT     = 12'h014;
    localparam logic [11:0] OFS_BOOTMAP    = 12'h018;
    localparam logic [11:0] OFS_WBUF       = 12'h100;
    // command codes in cmd[7:0]; argument in cmd[23:8]
    localparam logic [7:0]  CMD_DESCR      = 8'h00;
    localparam logic [7:0]  CMD_PROG       = 8'h01;
    localparam logic [7:0]  CMD_ERASE_PAGE = 8'h02;
    localparam logic [7:0]  CMD_ERASE_ALL  = 8'h05;
    localparam logic [7:0]  CMD_SET_LOCK   = 8'h08;
    localparam logic [7:0]  CMD_CLR_LOCK   = 8'h09;
    localparam logic [7:0]  CMD_SET_NVM    = 8'h0B;
    localparam logic [7:0]  CMD_CLR_NVM    = 8'h0C;
    // status bits
    localparam int          ST_READY       = 0;
    localparam int          ST_LOCKERR     = 1;
    localparam int          ST_CMDERR      = 2;
    localparam int          CFG_WIDE       = 0;
    localparam logic [31:0] CFG_RESET      = 32'h0000_0001;
    // boot map values
    localparam logic [31:0] ROM_BASE       = 32'h0018_0000;
    // identity, value arbitrary
    localparam logic [31:0] DEVICE_ID      = 32'h1234_5678;
    localparam logic [127:0] UNIQUE_ID     = 128'h0123_4567_89AB_CDEF_0011_2233_4455_6677;
    localparam logic [15:0] CALIB_BITS     = 16'hA5A5;
    // erase pin debounce
    localparam int          CLK_HZ         = 50_000_000;
    localparam int          ERASE_IGN_MS   = 100;
    localparam int          ERASE_ACC_MS   = 220;
    localparam int          ERASE_ACC_CYC  = CLK_HZ / 1000 * ERASE_ACC_MS;
    localparam int          ERASE_IGN_CYC  = CLK_HZ / 1000 * ERASE_IGN_MS;
    // programming port modes
    localparam logic [3:0]  PM_CMD         = 4'h0;
    localparam logic [3:0]  PM_ADDR        = 4'h1;
    localparam logic [3:0]  PM_DATA        = 4'h5;
    typedef enum logic [2:0] {FP_IDLE, FP_TAKE, FP_READY} fpbc_port_e;
endpackage : fpbc_pkg

/* File: fpbc_top.sv */
// flash protection, security, boot selection and programming port
// assumes APB master, pins synchronous to clk, pin strap pins held at reset release
// How it works
// - 32 lock regions of 64 pages, one lock bit each
// - erase or program on a locked region aborts and flags lock error
// - set-lock and clear-lock commands set or clear addressed region lock bit
// - accepted erase pin clears all lock bits
// - security bit refuses debug and programming port flash access
// - security set only by command; cleared only by erase pin full erase
// - calibration bits and unique id are constants, erase pin ignores them
// - programming mode entered on strap pins at external reset rise
// - programming port carries read, program, erase, lock, unlock, protect
// - port has 16-bit data, 4-bit mode, strobe, ready, oe, valid
// - three nvm bits, each set by a dedicated command; bits 1 and 2 also cleared by one
// - nvm bit 1 maps flash at zero, cleared maps boot rom
// - accepted erase pin clears nvm bit 1
// - nvm bit 2 selects boot bank 1, else bank 0
// - boot rom stays mapped at its fixed address always
// - two banks of 1024 pages of 256 bytes
// - 128-byte write buffer written as 32-bit words
// - software picks 128-bit or 64-bit read access width
// - descriptor command returns flash organisation
// - erase pin ignored under 100 ms, accepted after 220 ms
//
// The APB slave port and the register addresses were left to the implementer.
module fpbc_top
    import fpbc_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_ACC_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        erasePin,
    input  wire logic        debugReq,
    output logic             debugAllowed,
    output logic             flashAtZero,
    output logic             bootBank,
    output logic             wideRead,
    output logic             lockError,
    input  wire logic        testModePin,
    input  wire logic        extResetPin_n,
    input  wire logic [3:0]  strapLines,
    input  wire logic        progCmdStrobe_n,
    input  wire logic [3:0]  progModeSel,
    input  wire logic        progOutputEn_n,
    input  wire logic [15:0] progDataIn,
    output logic [15:0]      progDataOut,
    output logic             progDataOe,
    output logic             progReadyOut,
    output logic             progValid_n,
    output logic             progMode
);
    logic [LOCK_BITS-1:0]  lockBits;
    logic [GENERAL_NVM_BITS_BITS-1:0] nvm;
    logic [31:0]           status;
    logic [31:0]           result;
    logic [31:0]           cfg;
    logic [31:0]           wbuf [WBUF_WORDS];
    logic [31:0]           eraseCnt;
    logic                  eraseDone;
    logic                  bootSampled;
    logic                  extResetPrev;
    fpbc_port_e            portState;
    logic [15:0]           portCmd;

    logic                  lockErrFlag;
    logic                  cmdErrFlag;
    fpbc_port_e            next_portState;

    // apb decode
    wire        setupPh  = psel && !penable;
    wire        wrAcc    = psel && penable && pwrite;
    wire        rdAcc    = psel && penable && !pwrite;
    wire        selCmd   = paddr == OFS_CMD;
    wire        selStat  = paddr == OFS_STATUS;
    wire        selLock  = paddr == OFS_LOCK;
    wire        selNvm   = paddr == OFS_NVM;
    wire        selCfg   = paddr == OFS_CFG;
    wire        selRes   = paddr == OFS_RESULT;
    wire        selBoot  = paddr == OFS_BOOTMAP;
    // write buffer window is 32 words, nothing aliases above it
    wire        isWbuf   = paddr[11:7] == OFS_WBUF[11:7];
    wire        isKnown  = isWbuf || selCmd || selStat || selLock
                        || selNvm || selCfg || selRes || selBoot;
    wire        statRead = rdAcc && selStat;
    wire        cfgWrite = wrAcc && selCfg;
    wire        bufWrite = wrAcc && isWbuf;
    wire [4:0]  bufIdx   = paddr[6:2];
    // software command or port command share one execute path
    wire        swCmd    = wrAcc && selCmd;
    wire        portLive = progMode && !nvm[0];
    wire        pCmd     = portLive && portState == FP_TAKE;
    wire [7:0]  cmdOp    = pCmd ? portCmd[7:0] : pwdata[7:0];
    wire [15:0] cmdArg   = pCmd ? progDataIn : pwdata[23:8];
    wire        doCmd    = swCmd || pCmd;
    wire [4:0]  region   = cmdArg[15:11];
    wire        target   = cmdOp == CMD_PROG || cmdOp == CMD_ERASE_PAGE;
    wire        locked   = lockBits[region];
    wire        abort    = doCmd && target && locked;
    wire        opSetLk  = doCmd && cmdOp == CMD_SET_LOCK;
    wire        opClrLk  = doCmd && cmdOp == CMD_CLR_LOCK;
    wire        nvmInRng = cmdArg < 16'(GENERAL_NVM_BITS_BITS);
    wire        nvmZero  = cmdArg == 16'h0;
    wire [1:0]  nvmIdx   = cmdArg[1:0];
    wire        opSetNvm = doCmd && cmdOp == CMD_SET_NVM && nvmInRng;
    // security bit is never cleared by a command
    wire        opClrNvm = doCmd && cmdOp == CMD_CLR_NVM && nvmInRng && !nvmZero;
    wire        clrNvmBad = doCmd && cmdOp == CMD_CLR_NVM && nvmZero;
    wire        opDescr  = doCmd && cmdOp == CMD_DESCR;
    wire        opNvmAny = doCmd && cmdOp == CMD_SET_NVM;
    // erase pin debounce: counts while high, restarts when low
    wire        eraseAcc = eraseCnt == ERASE_CYC - 1 && erasePin;
    wire        eraseHit = eraseAcc && !eraseDone;
    wire [31:0] next_eraseCnt = !erasePin ? 32'h0
                              : (eraseAcc ? eraseCnt : eraseCnt + 32'h1);
    // register read data
    wire [31:0] descr    = {8'(PAGES_PER_LOCK), 8'(LOCK_BITS), 16'(PAGES_PER_BANK)};
    wire [31:0] bootWord = flashAtZero ? 32'h0 : ROM_BASE;
    wire [31:0] rdMux    = isWbuf  ? wbuf[bufIdx] :
                           selStat ? status :
                           selLock ? lockBits :
                           selNvm  ? {29'h0, nvm} :
                           selCfg  ? cfg :
                           selRes  ? result :
                           selBoot ? bootWord :
                           32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eraseCnt  <= 32'h0;
            eraseDone <= 1'b0;
        end else begin
            eraseCnt  <= next_eraseCnt;
            eraseDone <= eraseAcc;
        end
    end

    // one lock bit per region; erase pin wins over commands
    generate
        for (genvar g = 0; g < LOCK_BITS; g++) begin : g_lock
            logic lockQ;
            wire  hitRegion = region == 5'(g);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lockQ <= 1'b0;
                end else if (eraseHit) begin
                    lockQ <= 1'b0;
                end else if (opSetLk && hitRegion) begin
                    lockQ <= 1'b1;
                end else if (opClrLk && hitRegion) begin
                    lockQ <= 1'b0;
                end
            end
            assign lockBits[g] = lockQ;
        end
        // nvm bits; erase pin clears only bits 0 and 1
        for (genvar g = 0; g < GENERAL_NVM_BITS_BITS; g++) begin : g_nvm
            logic nvmQ;
            wire  hitBit   = nvmIdx == 2'(g);
            wire  eraseClr = eraseHit && g < 2;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    nvmQ <= 1'b0;
                end else if (eraseClr) begin
                    nvmQ <= 1'b0;
                end else if (opSetNvm && hitBit) begin
                    nvmQ <= 1'b1;
                end else if (opClrNvm && hitBit) begin
                    nvmQ <= 1'b0;
                end
            end
            assign nvm[g] = nvmQ;
        end
    endgenerate

    // sticky error flags: read clears, a new event in the same cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockErrFlag <= 1'b0;
        end else begin
            lockErrFlag <= abort || (lockErrFlag && !statRead);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdErrFlag <= 1'b0;
        end else begin
            cmdErrFlag <= clrNvmBad || (cmdErrFlag && !statRead);
        end
    end
    assign status = {29'h0, cmdErrFlag, lockErrFlag, 1'b1};

    // descriptor and set-nvm commands update the result word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= 32'h0;
        end else if (opDescr) begin
            result <= descr;
        end else if (opNvmAny) begin
            result <= 32'h0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
        end else if (cfgWrite) begin
            cfg <= {31'h0, pwdata[CFG_WIDE]};
        end
    end

    generate
        for (genvar i = 0; i < WBUF_WORDS; i++) begin : g_wbuf
            always_ff @(posedge clk) begin
                if (bufWrite && bufIdx == 5'(i)) begin
                    wbuf[i] <= pwdata;
                end
            end
        end
    endgenerate

    // apb answer: pready in the access phase, no wait states
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= setupPh;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else begin
            prdata <= (setupPh && !pwrite) ? rdMux : 32'h0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setupPh && !isKnown;
        end
    end

    // boot mapping and programming mode entry
    wire extResetRise = !extResetPrev && extResetPin_n;
    wire strapOk      = testModePin && strapLines == 4'b0011;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extResetPrev <= 1'b0;
        end else begin
            extResetPrev <= extResetPin_n;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bootSampled <= 1'b0;
        end else begin
            bootSampled <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flashAtZero <= 1'b0;
            bootBank    <= 1'b0;
        end else if (!bootSampled) begin
            flashAtZero <= nvm[1];
            bootBank    <= nvm[2];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progMode <= 1'b0;
        end else if (extResetRise) begin
            progMode <= strapOk;
        end
    end

    // programming port handshake
    wire portTake = portState == FP_IDLE && progMode && !progCmdStrobe_n;
    wire portEnd  = portState == FP_READY && progCmdStrobe_n;
    wire inTake   = portState == FP_TAKE;
    always_comb begin
        next_portState = portState;
        case (portState)
            FP_IDLE: begin
                if (portTake) begin
                    next_portState = (progModeSel == PM_DATA) ? FP_TAKE : FP_READY;
                end
            end
            FP_TAKE: begin
                next_portState = FP_READY;
            end
            FP_READY: begin
                if (progCmdStrobe_n) begin
                    next_portState = FP_IDLE;
                end
            end
            default: begin
                next_portState = FP_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portState <= FP_IDLE;
        end else begin
            portState <= next_portState;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portCmd <= 16'h0;
        end else if (portTake && progModeSel == PM_CMD) begin
            portCmd <= progDataIn;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progReadyOut <= 1'b1;
        end else if (portTake) begin
            progReadyOut <= 1'b0;
        end else if (portEnd) begin
            progReadyOut <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progValid_n <= 1'b1;
        end else if (inTake) begin
            progValid_n <= nvm[0];
        end else if (portEnd) begin
            progValid_n <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progDataOut <= 16'h0;
        end else if (inTake) begin
            progDataOut <= nvm[0] ? 16'h0 : result[15:0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progDataOe <= 1'b0;
        end else begin
            progDataOe <= portLive && !progOutputEn_n;
        end
    end

    // outputs taken from internal state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            debugAllowed <= 1'b0;
        end else begin
            debugAllowed <= debugReq && !nvm[0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wideRead <= 1'b1;
        end else begin
            wideRead <= cfg[CFG_WIDE];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockError <= 1'b0;
        end else begin
            lockError <= lockErrFlag;
        end
    end

    // fixed factory values, read-only
    wire unusedConst = ^{UNIQUE_ID, CALIB_BITS, DEVICE_ID};
endmodule : fpbc_top

/* File: fpbc_top_sva.sv */
// assertions on the ports of the flash protection block
// assumes one clock domain with an asynchronous active-low reset
module fpbc_top_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic debugReq,
    input wire logic debugAllowed,
    input wire logic flashAtZero,
    input wire logic bootBank,
    input wire logic progMode,
    input wire logic progCmdStrobe_n,
    input wire logic progReadyOut,
    input wire logic progValid_n,
    input wire logic progDataOe,
    input wire logic progOutputEn_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    slverr_qual_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    debug_block_a: assert property (!debugReq |=> !debugAllowed)
        else $error("debug allowed without request");
    boot_hold_a: assert property ($past(rst_n) |-> $stable(flashAtZero) && $stable(bootBank))
        else $error("boot mapping changed");
    port_take_a: assert property (progMode && progReadyOut && $fell(progCmdStrobe_n)
        |=> !progReadyOut)
        else $error("port command not taken");
    valid_gate_a: assert property (!progValid_n |-> progMode && !progReadyOut)
        else $error("valid outside transfer");
    port_release_a: assert property (progCmdStrobe_n && !progReadyOut |=> progReadyOut)
        else $error("ready not back after strobe");
    oe_gate_a: assert property (progDataOe |-> progMode && $past(!progOutputEn_n))
        else $error("port driven without output enable");
endmodule : fpbc_top_sva

bind fpbc_top fpbc_top_sva chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .debugReq(debugReq), .debugAllowed(debugAllowed),
    .flashAtZero(flashAtZero), .bootBank(bootBank), .progMode(progMode),
    .progCmdStrobe_n(progCmdStrobe_n), .progReadyOut(progReadyOut), .progValid_n(progValid_n),
    .progDataOe(progDataOe), .progOutputEn_n(progOutputEn_n));

/* File: fpbc_prog_model.sv */
// external programmer on the handshaked parallel port
// assumes the block has entered programming mode before xfer is called
module fpbc_prog_model
    import fpbc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        progReadyOut,
    input  wire logic        progValid_n,
    input  wire logic [15:0] progDataOut,
    output logic             progCmdStrobe_n,
    output logic [3:0]       progModeSel,
    output logic             progOutputEn_n,
    output logic [15:0]      progDataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        progCmdStrobe_n = 1'b1;
        progModeSel     = PM_CMD;
        progOutputEn_n  = 1'b1;
        progDataIn      = 16'h0000;
    end
    task automatic xfer(input logic [3:0] m, input logic [15:0] d, output logic seen,
                        output logic [15:0] dout);
        int n;
        logic bad;
        seen = 1'b0;
        dout = 16'h0000;
        progCmdStrobe_n <= 1'b0;
        progModeSel     <= m;
        progDataIn      <= d;
        progOutputEn_n  <= (m != PM_DATA);
        n = 0;
        do begin @(posedge clk); n++; end while (progReadyOut && n < 20);
        bad = progReadyOut;
        repeat (3) begin
            @(posedge clk);
            seen |= !progValid_n;
            if (!progValid_n) dout = progDataOut;
        end
        progCmdStrobe_n <= 1'b1;
        progOutputEn_n  <= 1'b1;
        progDataIn      <= ~d; // released bus, not a held value
        n = 0;
        do begin @(posedge clk); n++; end while (!progReadyOut && n < 20);
        // a hung handshake shows as unknown and fails the caller's compare
        if (bad || !progReadyOut) seen = 1'bx;
    endtask : xfer
endmodule : fpbc_prog_model

/* File: test_flash_protect_boot_config.sv */
// self-checking bench for the flash protection block
// assumes the checker is bound through its own file
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_flash_protect_boot_config;
    import fpbc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, erasePin, debugReq, debugAllowed;
    logic flashAtZero, bootBank, wideRead, lockError, testModePin, extResetPin_n, progMode;
    logic strb_n, oe_n, progDataOe, progReadyOut, progValid_n, seen;
    logic [3:0] strapLines, msel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, wv;
    logic [15:0] pdi, progDataOut, dout;
    logic [33:0] exq[$], e;
    logic [4:0] r;
    int errors = 0, samples_checked = 0;
    fpbc_top #(.ERASE_CYC(50)) uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .erasePin(erasePin), .debugReq(debugReq), .debugAllowed(debugAllowed),
        .flashAtZero(flashAtZero), .bootBank(bootBank), .wideRead(wideRead),
        .lockError(lockError), .testModePin(testModePin), .extResetPin_n(extResetPin_n),
        .strapLines(strapLines), .progCmdStrobe_n(strb_n), .progModeSel(msel),
        .progOutputEn_n(oe_n), .progDataIn(pdi), .progDataOut(progDataOut),
        .progDataOe(progDataOe), .progReadyOut(progReadyOut), .progValid_n(progValid_n),
        .progMode(progMode));
    fpbc_prog_model pm (.clk(clk), .progReadyOut(progReadyOut), .progValid_n(progValid_n),
        .progDataOut(progDataOut),
        .progCmdStrobe_n(strb_n), .progModeSel(msel), .progOutputEn_n(oe_n), .progDataIn(pdi));
    always #10 clk = ~clk;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] x);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        if (!w) exq.push_back(x);
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (!pready && n < 50);
        if (!pready) begin
            errors++;
            print_verdict();
        end else begin
            psel <= 1'b0; penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {2'b10, x});
    endtask : rd
    task automatic cmd(input logic [7:0] o, input logic [15:0] a);
        apb(1'b1, OFS_CMD, {8'h00, a, o}, 34'h0);
    endtask : cmd
    always @(posedge clk) if (psel && penable && pready && !pwrite && exq.size() > 0) begin
        e = exq.pop_front();
        `CHK("pslverr", e[32], pslverr)
        if (e[33]) `CHK("prdata", e[31:0], prdata)
    end
    initial begin
        clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        erasePin = 0; debugReq = 1; testModePin = 1; extResetPin_n = 0; strapLines = 4'h7;
        void'($urandom(32'hCC16DC8B));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        extResetPin_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("progMode", 1'b0, progMode)
        extResetPin_n <= 1'b0; strapLines <= 4'h3;
        @(posedge clk);
        extResetPin_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("progMode", 1'b1, progMode)
        rd(OFS_CFG, CFG_RESET);
        apb(1'b1, OFS_CFG, 32'h0, 34'h0);
        repeat (2) @(posedge clk);
        `CHK("wideRead", 1'b0, wideRead)
        apb(1'b0, 12'h0FC, 32'h0, {2'b01, 32'h0});
        wv = $urandom;
        apb(1'b1, OFS_WBUF + 12'h07C, wv, 34'h0);
        rd(OFS_WBUF + 12'h07C, wv);
        apb(1'b0, OFS_WBUF + 12'h080, 32'h0, {2'b01, 32'h0});
        r = 5'($urandom_range(31));
        cmd(CMD_SET_LOCK, {r, 11'h000});
        rd(OFS_LOCK, 32'h1 << r);
        cmd(CMD_PROG, {r, 11'($urandom)});
        repeat (2) @(posedge clk);
        `CHK("lockError", 1'b1, lockError)
        rd(OFS_STATUS, 32'h3);
        rd(OFS_STATUS, 32'h1);
        cmd(CMD_ERASE_PAGE, {r ^ 5'h01, 11'h000});
        rd(OFS_STATUS, 32'h1);
        cmd(CMD_CLR_LOCK, {r, 11'h000});
        rd(OFS_LOCK, 32'h0);
        for (int i = 1; i < GENERAL_NVM_BITS_BITS; i++) cmd(CMD_SET_NVM, 16'(i));
        rd(OFS_NVM, 32'h6);
        `CHK("flashAtZero", 1'b0, flashAtZero)
        `CHK("bootBank", 1'b0, bootBank)
        rd(OFS_BOOTMAP, ROM_BASE);
        cmd(CMD_CLR_NVM, 16'h0);
        rd(OFS_STATUS, 32'h5);
        pm.xfer(PM_DATA, 16'($urandom), seen, dout);
        `CHK("valid", 1'b1, seen)
        rd(OFS_RESULT, 32'h4020_0400);
        cmd(CMD_SET_NVM, 16'h0);
        cmd(CMD_SET_LOCK, {r, 11'h000});
        rd(OFS_NVM, 32'h7);
        `CHK("debugAllowed", 1'b0, debugAllowed)
        pm.xfer(PM_DATA, 16'($urandom), seen, dout);
        `CHK("valid", 1'b0, seen)
        erasePin <= 1'b1;
        repeat (10) @(posedge clk);
        erasePin <= 1'b0;
        rd(OFS_NVM, 32'h7);
        erasePin <= 1'b1;
        repeat (60) @(posedge clk);
        erasePin <= 1'b0;
        rd(OFS_LOCK, 32'h0);
        rd(OFS_NVM, 32'h4);
        `CHK("debugAllowed", 1'b1, debugAllowed)
        debugReq <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("debugAllowed", 1'b0, debugAllowed)
        debugReq <= 1'b1;
        pm.xfer(PM_DATA, 16'($urandom), seen, dout);
        `CHK("valid", 1'b1, seen)
        pm.xfer(PM_DATA, 16'($urandom), seen, dout);
        `CHK("progDataOut", 16'h0400, dout)
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule : test_flash_protect_boot_config
